/* File: rtl/tss_consts.svh */
// constants for the trigger source select block
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
`define TSS_SRC_FREE 2'h0
`define TSS_SRC_EXT 2'h1
`define TSS_SRC_BUS 2'h2
`define TSS_POL_RISE 1'h1
`define TSS_POL_FALL 1'h0
`define TSS_OPER_WAIT_BIT 5
`define TSS_OPER_WIDTH 16
`define TSS_QUEUE_DEPTH 4
`define TSS_QUEUE_AW 2
`endif

/* File: rtl/tss_pkg.sv */
// types for the trigger source select block
package tss_pkg;
  typedef enum logic [1:0] {
    TSS_SRC_FREE_RUN = 2'h0,
    TSS_SRC_EXTERNAL = 2'h1,
    TSS_SRC_BUS_CMD = 2'h2
  } tss_source_t;
  typedef enum logic [2:0] {
    TSS_IDLE = 3'h1,
    TSS_WAITING = 3'h2,
    TSS_FIRED = 3'h4
  } tss_state_t;
  typedef struct packed {
    tss_source_t source;
    logic edgePolarity;
  } tss_setting_t;
endpackage

/* File: rtl/tss_cmd_queue.sv */
// small in-order queue of immediate trigger commands
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_cmd_queue (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pushValid,
  output logic pushReady,
  input wire logic popReady,
  output logic popValid
);
  logic [`TSS_QUEUE_AW:0] count_reg;
  logic [`TSS_QUEUE_AW:0] count_next;
  assign pushReady = (count_reg != 3'(`TSS_QUEUE_DEPTH));
  assign popValid = (count_reg != 3'h0);
  always_comb begin
    count_next = count_reg;
    if (pushValid && pushReady && !(popValid && popReady)) begin
      count_next = count_reg + 3'h1;
    end else if (!(pushValid && pushReady) && popValid && popReady) begin
      count_next = count_reg - 3'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_reg <= 3'h0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

/* File: rtl/tss_trigger_select.sv */
// trigger source selection, edge detection and waiting status
// Notes on behaviour
// - the external edge polarity is settable to rising or falling, and preset forces falling.
// - the source setting holds free-run, external or bus, preset picks free-run, and it reads back.
// - in free-run the block fires as soon as it is armed.
// - in external mode a transition of the set polarity on the external input fires the block; after preset that is high-to-low.
// - in bus mode the star trigger, immediate trigger command or group execute trigger all fire it.
// - edges, star or group triggers arriving while not waiting have no effect; an immediate command popped from the queue while not waiting is dropped.
// - bit 5 of the operation condition word is 1 exactly while waiting to trigger.
// - immediate trigger commands are queued in order while group execute trigger acts at once.
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_trigger_select (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic preset,
  input wire logic settingWrite,
  input wire tss_pkg::tss_setting_t settingIn,
  output tss_pkg::tss_setting_t settingOut,
  input wire logic arm,
  input wire logic extTrigIn,
  input wire logic starTrgCmd,
  input wire logic immediateTriggerCommand,
  output logic immCmdReady,
  input wire logic groupExecTrig,
  input wire logic cmdDone,
  output logic triggerOut,
  output logic [`TSS_OPER_WIDTH-1:0] operCondition
);
  tss_pkg::tss_setting_t setting_reg;
  tss_pkg::tss_state_t state_reg;
  logic extPrev_reg;
  logic queuedTrig;
  logic popValid;
  logic waiting;
  logic extEdge;
  logic busTrig;
  logic fire;

  assign waiting = (state_reg == tss_pkg::TSS_WAITING);

  // preset wins over a write so the defaults are always reachable
  always_ff @(posedge mclk) begin
    if (!reset_n || preset) begin
      setting_reg.source <= tss_pkg::TSS_SRC_FREE_RUN;
      setting_reg.edgePolarity <= `TSS_POL_FALL;
    end else if (settingWrite && settingIn.source != tss_pkg::tss_source_t'(2'h3)) begin
      setting_reg <= settingIn;
    end
  end
  assign settingOut = setting_reg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      extPrev_reg <= 1'h1;
    end else begin
      extPrev_reg <= extTrigIn;
    end
  end
  // edge sense follows polarity; falling is the preset default
  assign extEdge = (setting_reg.edgePolarity == `TSS_POL_RISE) ? (extTrigIn && !extPrev_reg)
                                                               : (!extTrigIn && extPrev_reg);

  // queue drains one command per cycle; an entry popped while not waiting is simply dropped
  tss_cmd_queue u_queue (
    .mclk(mclk),
    .reset_n(reset_n),
    .pushValid(immediateTriggerCommand),
    .pushReady(immCmdReady),
    .popReady(cmdDone),
    .popValid(popValid)
  );
  assign queuedTrig = popValid && cmdDone;
  assign busTrig = starTrgCmd || queuedTrig || groupExecTrig;

  always_comb begin
    fire = 1'b0;
    if (waiting) begin
      case (setting_reg.source)
        tss_pkg::TSS_SRC_FREE_RUN: fire = 1'b1;
        tss_pkg::TSS_SRC_EXTERNAL: fire = extEdge;
        tss_pkg::TSS_SRC_BUS_CMD: fire = busTrig;
        default: fire = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || preset) begin
      state_reg <= tss_pkg::TSS_IDLE;
    end else begin
      case (state_reg)
        tss_pkg::TSS_IDLE: begin
          if (arm) begin
            state_reg <= tss_pkg::TSS_WAITING;
          end
        end
        tss_pkg::TSS_WAITING: begin
          if (fire) begin
            state_reg <= tss_pkg::TSS_FIRED;
          end
        end
        tss_pkg::TSS_FIRED: state_reg <= tss_pkg::TSS_IDLE;
        default: state_reg <= tss_pkg::TSS_IDLE;
      endcase
    end
  end

  // the wait bit is built from the next state so it lines up with state_reg
  always_ff @(posedge mclk) begin
    if (!reset_n || preset) begin
      triggerOut <= 1'b0;
      operCondition <= '0;
    end else begin
      triggerOut <= fire;
      operCondition <= '0;
      operCondition[`TSS_OPER_WAIT_BIT] <= (state_reg == tss_pkg::TSS_IDLE) ? arm
                                          : (waiting && !fire);
    end
  end

  property p_wait_bit;
    @(posedge mclk) disable iff (!reset_n)
    !preset && state_reg == tss_pkg::TSS_IDLE && arm |=> operCondition[`TSS_OPER_WAIT_BIT];
  endproperty
  a_wait_bit: assert property (p_wait_bit) else $error("arm did not raise the wait bit");
  property p_wait_tracks;
    @(posedge mclk) disable iff (!reset_n)
    operCondition[`TSS_OPER_WAIT_BIT] == waiting;
  endproperty
  a_wait_tracks: assert property (p_wait_tracks) else $error("wait bit differs from waiting state");
  property p_no_fire_idle;
    @(posedge mclk) disable iff (!reset_n)
    !waiting |=> !triggerOut;
  endproperty
  a_no_fire_idle: assert property (p_no_fire_idle) else $error("trigger while not waiting");
  property p_free_run;
    @(posedge mclk) disable iff (!reset_n)
    waiting && !preset && setting_reg.source == tss_pkg::TSS_SRC_FREE_RUN |=> triggerOut;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free-run did not fire at once");
  property p_ext_fall;
    @(posedge mclk) disable iff (!reset_n)
    waiting && !preset && setting_reg.source == tss_pkg::TSS_SRC_EXTERNAL && setting_reg.edgePolarity == 1'b0
      && $fell(extTrigIn) |=> triggerOut;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("falling edge missed");
  property p_ext_pol;
    @(posedge mclk) disable iff (!reset_n)
    waiting && setting_reg.source == tss_pkg::TSS_SRC_EXTERNAL && setting_reg.edgePolarity == 1'b1
      && !$rose(extTrigIn) |=> !triggerOut;
  endproperty
  a_ext_pol: assert property (p_ext_pol) else $error("fired without rising edge");
  property p_get;
    @(posedge mclk) disable iff (!reset_n)
    waiting && !preset && setting_reg.source == tss_pkg::TSS_SRC_BUS_CMD && groupExecTrig |=> triggerOut;
  endproperty
  a_get: assert property (p_get) else $error("group trigger not immediate");
  property p_preset;
    @(posedge mclk) disable iff (!reset_n)
    preset |=> settingOut.source == tss_pkg::TSS_SRC_FREE_RUN && settingOut.edgePolarity == 1'b0;
  endproperty
  a_preset: assert property (p_preset) else $error("preset defaults wrong");
  property p_legal_src;
    @(posedge mclk) disable iff (!reset_n)
    settingOut.source != tss_pkg::tss_source_t'(2'h3);
  endproperty
  a_legal_src: assert property (p_legal_src) else $error("illegal source code");
  property p_cmd_q;
    @(posedge mclk) disable iff (!reset_n)
    popValid && cmdDone && waiting && !preset && setting_reg.source == tss_pkg::TSS_SRC_BUS_CMD |=> triggerOut;
  endproperty
  a_cmd_q: assert property (p_cmd_q) else $error("queued command did not fire");
  // preset beats a write at the same edge, so it is kept out of the antecedent
  property p_write_readback;
    @(posedge mclk) disable iff (!reset_n)
    !preset && settingWrite && settingIn.source != tss_pkg::tss_source_t'(2'h3) |=> settingOut == $past(settingIn);
  endproperty
  a_write_readback: assert property (p_write_readback) else $error("setting write not read back");
  property p_oper_clear;
    @(posedge mclk) disable iff (!reset_n)
    operCondition[`TSS_OPER_WIDTH-1:`TSS_OPER_WAIT_BIT+1] == '0 && operCondition[`TSS_OPER_WAIT_BIT-1:0] == '0;
  endproperty
  a_oper_clear: assert property (p_oper_clear) else $error("status bits other than wait are set");
  property p_pulse;
    @(posedge mclk) disable iff (!reset_n)
    triggerOut |=> !triggerOut;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger pulse longer than one cycle");
  property p_ext_rise;
    @(posedge mclk) disable iff (!reset_n)
    waiting && !preset && setting_reg.source == tss_pkg::TSS_SRC_EXTERNAL && setting_reg.edgePolarity == `TSS_POL_RISE
      && $rose(extTrigIn) |=> triggerOut;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rising edge missed");
  property p_bus_quiet;
    @(posedge mclk) disable iff (!reset_n)
    waiting && setting_reg.source == tss_pkg::TSS_SRC_BUS_CMD && !starTrgCmd && !groupExecTrig
      && !(popValid && cmdDone) |=> !triggerOut;
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("bus mode fired without a command");
  property p_free_oper;
    @(posedge mclk) disable iff (!reset_n)
    waiting && !preset && setting_reg.source == tss_pkg::TSS_SRC_FREE_RUN |=> !operCondition[`TSS_OPER_WAIT_BIT];
  endproperty
  a_free_oper: assert property (p_free_oper) else $error("free-run left the wait bit set");
  property p_preset_out;
    @(posedge mclk) disable iff (!reset_n)
    preset |=> !triggerOut && operCondition == '0 && state_reg == tss_pkg::TSS_IDLE;
  endproperty
  a_preset_out: assert property (p_preset_out) else $error("preset left the block busy");
  // covers: one firing per source, and a group trigger past a full queue
  c_ext: cover property (@(posedge mclk) disable iff (!reset_n)
    setting_reg.source == tss_pkg::TSS_SRC_EXTERNAL && triggerOut);
  c_bus: cover property (@(posedge mclk) disable iff (!reset_n)
    setting_reg.source == tss_pkg::TSS_SRC_BUS_CMD && triggerOut);
  c_free: cover property (@(posedge mclk) disable iff (!reset_n)
    setting_reg.source == tss_pkg::TSS_SRC_FREE_RUN && triggerOut);
  c_full: cover property (@(posedge mclk) disable iff (!reset_n)
    !immCmdReady && groupExecTrig);
endmodule

/* File: verif/tss_remote_model.sv */
// remote controller and external TTL trigger source model
`timescale 1ns/1ps
module tss_remote_model (
  input wire logic mclk,
  output logic extTrigIn,
  output logic starTrgCmd,
  output logic immediateTriggerCommand,
  output logic groupExecTrig,
  output logic cmdDone
);
  initial begin
    extTrigIn = 1'h1;
    starTrgCmd = 1'h0;
    immediateTriggerCommand = 1'h0;
    groupExecTrig = 1'h0;
    cmdDone = 1'h1;
  end
  // kind 0 idle line, 1 fall, 2 rise, 3 star, 4 queued, 5 group
  // each edge is left where it lands; a lone rise needs the line taken low earlier, while idle
  task automatic send(input int kind);
    @(negedge mclk);
    case (kind)
      0: extTrigIn = 1'h1;
      1: extTrigIn = 1'h0;
      2: extTrigIn = 1'h1;
      3: starTrgCmd = 1'h1;
      4: immediateTriggerCommand = 1'h1;
      5: groupExecTrig = 1'h1;
      default: ;
    endcase
    @(negedge mclk);
    starTrgCmd = 1'h0;
    immediateTriggerCommand = 1'h0;
    groupExecTrig = 1'h0;
  endtask
  task automatic stall(input logic v);
    @(negedge mclk);
    cmdDone = v;
  endtask
endmodule

/* File: verif/tb_tss_trigger_select.sv */
// self-checking bench for the trigger source select block
`timescale 1ns/1ps
module tb_tss_trigger_select;
  typedef struct packed {
    logic [2:0] set;
    logic [2:0] kind;
    logic [3:0] fire;
  } tss_row_t;
  localparam tss_row_t ROWS [10] = '{
    '{3'h0, 3'h0, 4'h1},
    '{3'h2, 3'h1, 4'h1},
    '{3'h3, 3'h2, 4'h1},
    '{3'h3, 3'h1, 4'h0},
    '{3'h2, 3'h2, 4'h0},
    '{3'h4, 3'h3, 4'h1},
    '{3'h4, 3'h4, 4'h1},
    '{3'h4, 3'h5, 4'h1},
    '{3'h2, 3'h5, 4'h0},
    '{3'h4, 3'h1, 4'h0}};
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic preset = 1'h0;
  logic settingWrite = 1'h0;
  logic arm = 1'h0;
  tss_pkg::tss_setting_t settingIn = '0;
  tss_pkg::tss_setting_t settingOut;
  logic extTrigIn, starTrgCmd, immCmd, groupExecTrig, cmdDone, immCmdReady, triggerOut;
  logic [15:0] operCondition;
  logic [3:0] fireCount = 4'h0;
  int errors = 0;
  int n_compared = 0;
  always #12.5 mclk = ~mclk;
  // counting pulses catches both a missed fire and a doubled one
  always @(posedge mclk) fireCount <= (!reset_n || preset) ? 4'h0 : fireCount + {3'h0, triggerOut};
  tss_remote_model i_tss_remote_model (.mclk(mclk), .extTrigIn(extTrigIn), .starTrgCmd(starTrgCmd),
    .immediateTriggerCommand(immCmd), .groupExecTrig(groupExecTrig), .cmdDone(cmdDone));
  tss_trigger_select i_tss_trigger_select (.mclk(mclk), .reset_n(reset_n), .preset(preset),
    .settingWrite(settingWrite), .settingIn(settingIn), .settingOut(settingOut), .arm(arm),
    .extTrigIn(extTrigIn), .starTrgCmd(starTrgCmd), .immediateTriggerCommand(immCmd),
    .immCmdReady(immCmdReady), .groupExecTrig(groupExecTrig), .cmdDone(cmdDone),
    .triggerOut(triggerOut), .operCondition(operCondition));
  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_set(input tss_pkg::tss_setting_t got, input logic [2:0] exp);
    n_compared++;
    if (3'(got) !== exp) begin
      errors++;
      $display("mismatch at %0t: setting %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic arm_once;
    arm = 1'h1;
    cyc(1);
    arm = 1'h0;
  endtask
  // the line level is set under preset, so a rise row sees no fall after arming
  task automatic setup(input logic [2:0] s, input int pre);
    cyc(1);
    preset = 1'h1;
    i_tss_remote_model.send(pre);
    preset = 1'h0;
    chk_set(settingOut, 3'h0);
    settingWrite = 1'h1;
    settingIn = tss_pkg::tss_setting_t'(s);
    cyc(1);
    settingWrite = 1'h0;
    chk_set(settingOut, s);
    arm_once();
    chk_val(operCondition, 16'h0020);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    chk_val(operCondition, 16'h0000);
    chk_val({15'h0, triggerOut}, 16'h0000);
    chk_set(settingOut, 3'h0);
    reset_n = 1'h1;
    foreach (ROWS[i]) begin
      setup(ROWS[i].set, (ROWS[i].kind == 3'h2) ? 1 : 0);
      i_tss_remote_model.send(int'(ROWS[i].kind));
      cyc(8);
      chk_val({12'h0, fireCount}, {12'h0, ROWS[i].fire});
      chk_val(operCondition, ROWS[i].fire != 4'h0 ? 16'h0000 : 16'h0020);
    end
    // group trigger must overtake a full, stalled queue
    setup(3'h4, 0);
    i_tss_remote_model.stall(1'h0);
    repeat (4) i_tss_remote_model.send(4);
    chk_val({15'h0, immCmdReady}, 16'h0000);
    chk_val({12'h0, fireCount}, 16'h0000);
    i_tss_remote_model.send(5);
    cyc(4);
    chk_val({12'h0, fireCount}, 16'h0001);
    i_tss_remote_model.stall(1'h1);
    cyc(6);
    arm_once();
    cyc(6);
    chk_val({12'h0, fireCount}, 16'h0001);
    chk_val(operCondition, 16'h0020);
    // a second reset while waiting in bus mode must bring back the defaults
    reset_n = 1'h0;
    cyc(2);
    chk_val(operCondition, 16'h0000);
    chk_set(settingOut, 3'h0);
    reset_n = 1'h1;
    arm_once();
    chk_val(operCondition, 16'h0020);
    cyc(2);
    chk_val({12'h0, fireCount}, 16'h0001);
    // source code 3 is not one of the three sources and must not load
    settingIn = tss_pkg::tss_setting_t'(3'h7);
    settingWrite = 1'h1;
    cyc(1);
    settingWrite = 1'h0;
    chk_set(settingOut, 3'h0);
    close_out();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule
